// ### design/sbl_ctrl.sv
// controller end: issues one user command when it is legal, else holds off
// assumes the device end shares REF_CLK; keeps its own copy of bank timing
`timescale 1ns/1ps
module sbl_ctrl
	import sbl_pkg::*;
(
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	sbl_if.ctrl              LINK,
	input  wire logic        REQ_VALID,
	input  wire logic [3:0]  REQ_CMD,
	input  wire logic [BA_W-1:0] REQ_BANK,
	input  wire logic        REQ_CLOSE,
	input  wire logic        BURST_LEN8,
	output logic             REQ_READY,
	output logic             ISSUED
);
	// ------------------------------------------------------------
	// per-bank and global busy timers (conservative)
	// ------------------------------------------------------------
	logic [CNT_W-1:0] busy_reg [NUM_BANKS];
	logic [CNT_W-1:0] gbusy_reg;
	logic [NUM_BANKS-1:0] open_reg;
	logic             legal;
	logic             go;
	sbl_cmd_e         rc;
	logic             all_free;
	logic             bank_free;
	logic [CNT_W-1:0] burst_cyc;

	assign rc        = sbl_cmd_e'(REQ_CMD);
	assign burst_cyc = BURST_LEN8 ? BURST8_CYC : BURST4_CYC;
	assign bank_free = busy_reg[REQ_BANK] == CNT_ZERO && gbusy_reg == CNT_ZERO;

	always_comb begin
		all_free = gbusy_reg == CNT_ZERO;
		for (int i = 0; i < NUM_BANKS; i++) begin
			all_free = all_free && busy_reg[i] == CNT_ZERO && !open_reg[i];
		end
	end

	// only legal commands; never interrupt (wait out bursts)
	always_comb begin
		legal = 1'b0;
		case (rc)
			SBL_CMD_ROW_OPEN:  legal = bank_free && !open_reg[REQ_BANK];
			SBL_CMD_READ, SBL_CMD_WRITE: legal = bank_free && open_reg[REQ_BANK];
			SBL_CMD_PRECHARGE: legal = REQ_CLOSE ? all_free || (gbusy_reg == CNT_ZERO
				&& busy_reg[0] == CNT_ZERO && busy_reg[1] == CNT_ZERO
				&& busy_reg[2] == CNT_ZERO && busy_reg[3] == CNT_ZERO) : bank_free;
			SBL_CMD_REFRESH, SBL_CMD_MODE_LOAD: legal = all_free;
			SBL_CMD_NO_OP, SBL_CMD_DESELECT: legal = 1'b1;
			default: legal = 1'b0;
		endcase
	end
	assign go = REQ_VALID && legal;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			logic tgt;
			assign tgt = REQ_BANK == BA_W'(gi);
			always_ff @(posedge REF_CLK) begin
				if (RST) begin
					busy_reg[gi] <= CNT_ZERO;
					open_reg[gi] <= 1'b0;
				end else if (go && rc == SBL_CMD_ROW_OPEN && tgt) begin
					busy_reg[gi] <= ACT_ACCESS_CYC + 8'h02;
					open_reg[gi] <= 1'b1;
				end else if (go && (rc == SBL_CMD_READ || rc == SBL_CMD_WRITE) && tgt) begin
					busy_reg[gi] <= burst_cyc + WRITE_RECOVERY_CYC + 8'h02
						+ (REQ_CLOSE ? PRECHARGE_CYC : CNT_ZERO);
					open_reg[gi] <= !REQ_CLOSE;
				end else if (go && rc == SBL_CMD_PRECHARGE && (tgt || REQ_CLOSE)) begin
					busy_reg[gi] <= PRECHARGE_CYC + 8'h02;
					open_reg[gi] <= 1'b0;
				end else if (busy_reg[gi] != CNT_ZERO) begin
					busy_reg[gi] <= busy_reg[gi] - 8'h01;
				end
			end
		end
	endgenerate

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			gbusy_reg <= CNT_ZERO;
		end else if (go && rc == SBL_CMD_REFRESH) begin
			gbusy_reg <= ROW_CYCLE_CYC + 8'h02;
		end else if (go && rc == SBL_CMD_MODE_LOAD) begin
			gbusy_reg <= MODE_SET_CYC + 8'h02;
		end else if (gbusy_reg != CNT_ZERO) begin
			gbusy_reg <= gbusy_reg - 8'h01;
		end
	end

	// ------------------------------------------------------------
	// pin drive
	// ------------------------------------------------------------
	logic [3:0]      pins_reg;
	logic [BA_W-1:0] ba_reg;
	logic            close_reg;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			pins_reg  <= 4'hf;
			ba_reg    <= '0;
			close_reg <= 1'b0;
			REQ_READY <= 1'b0;
			ISSUED    <= 1'b0;
		end else begin
			pins_reg  <= go ? sbl_encode(rc) : 4'h7;
			ba_reg    <= REQ_BANK;
			close_reg <= REQ_CLOSE;
			REQ_READY <= go;
			ISSUED    <= go && rc != SBL_CMD_NO_OP && rc != SBL_CMD_DESELECT;
		end
	end
	assign LINK.cs_n           = pins_reg[3];
	assign LINK.ras_n          = pins_reg[2];
	assign LINK.cas_n          = pins_reg[1];
	assign LINK.we_n           = pins_reg[0];
	assign LINK.ba             = ba_reg;
	assign LINK.close_flag_bit = close_reg;
	assign LINK.cke            = 1'b1;
endmodule

// ### design/sbl_device.sv
// per-bank state tracking and command legality checking (device end)
// assumes command pins come from the controller on the same REF_CLK and are registered twice here
`timescale 1ns/1ps
module sbl_device
	import sbl_pkg::*;
(
	input  wire logic            REF_CLK,
	input  wire logic            RST,
	sbl_if.dev                   LINK,
	input  wire logic            BURST_LEN8,
	output logic [NUM_BANKS-1:0] BANK_IDLE,
	output logic [NUM_BANKS-1:0] BANK_ROW_ACTIVE,
	output logic                 ALL_IDLE,
	output logic                 CMD_VALID,
	output logic [3:0]           CMD_CODE,
	output logic [BA_W-1:0]      CMD_BANK,
	output logic                 ILLEGAL_CMD
);
	// ------------------------------------------------------------
	// input synchronisers
	// ------------------------------------------------------------
	logic [7:0] sync1_reg;
	logic [7:0] sync2_reg;
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			sync1_reg <= 8'hff;
			sync2_reg <= 8'hff;
		end else begin
			sync1_reg <= {LINK.cs_n, LINK.ras_n, LINK.cas_n, LINK.we_n,
				LINK.ba, LINK.close_flag_bit, LINK.cke};
			sync2_reg <= sync1_reg;
		end
	end

	sbl_cmd_e        cmd;
	logic [BA_W-1:0] cmd_ba;
	logic            cmd_close;
	logic            cmd_sel;
	assign cmd       = sbl_decode(sync2_reg[7:4]);
	assign cmd_ba    = sync2_reg[3:2];
	assign cmd_close = sync2_reg[1];
	assign cmd_sel   = cmd != SBL_CMD_DESELECT && cmd != SBL_CMD_NO_OP;

	// ------------------------------------------------------------
	// global refresh and mode-load state
	// ------------------------------------------------------------
	sbl_glob_e        glob_reg;
	logic [CNT_W-1:0] glob_cnt_reg;
	logic             all_idle;
	logic [NUM_BANKS-1:0] idle_vec;
	logic [NUM_BANKS-1:0] bank_bad;
	assign all_idle = &idle_vec;

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			glob_reg     <= SBL_GL_NONE;
			glob_cnt_reg <= CNT_ZERO;
		end else begin
			case (glob_reg)
				SBL_GL_NONE: begin
					if (all_idle && cmd == SBL_CMD_REFRESH) begin
						glob_reg     <= SBL_GL_REFRESH;
						glob_cnt_reg <= ROW_CYCLE_CYC - 8'h01;
					end else if (all_idle && cmd == SBL_CMD_MODE_LOAD) begin
						glob_reg     <= SBL_GL_MODE;
						glob_cnt_reg <= MODE_SET_CYC - 8'h01;
					end
				end
				SBL_GL_REFRESH, SBL_GL_MODE: begin
					if (glob_cnt_reg == CNT_ZERO) begin
						glob_reg <= SBL_GL_NONE;
					end else begin
						glob_cnt_reg <= glob_cnt_reg - 8'h01;
					end
				end
				default: glob_reg <= SBL_GL_NONE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// per-bank state machines
	// ------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < NUM_BANKS; gi++) begin : g_bank
			sbl_bank_e        st_reg;
			logic [CNT_W-1:0] cnt_reg;
			logic [CNT_W-1:0] burst_reg;
			logic             hit;
			logic             mine;
			logic             brd;
			logic             bwr;
			logic             bpre;
			logic             on_bound;
			assign hit  = cmd_ba == BA_W'(gi);
			assign brd  = cmd == SBL_CMD_READ && hit;
			assign bwr  = cmd == SBL_CMD_WRITE && hit;
			assign bpre = cmd == SBL_CMD_PRECHARGE && (hit || cmd_close);
			assign mine = cmd_sel && (hit || bpre);
			// beats come two per cycle, so the one boundary is two cycles into the burst
			assign on_bound = burst_reg == BURST4_CYC;
			assign idle_vec[gi] = st_reg == SBL_BK_IDLE;

			// other banks judged by own state
			always_comb begin
				bank_bad[gi] = 1'b0;
				case (st_reg)
					// precharge of an idle bank is a harmless no-op
					SBL_BK_IDLE:
						bank_bad[gi] = brd || bwr;
					SBL_BK_ACTIVE:
						bank_bad[gi] = cmd == SBL_CMD_ROW_OPEN && hit;
					SBL_BK_READ:
						bank_bad[gi] = (mine && !brd) || (brd && (!BURST_LEN8 || !on_bound));
					SBL_BK_WRITE:
						bank_bad[gi] = (mine && !bwr) || (bwr && (!BURST_LEN8 || !on_bound));
					SBL_BK_READ_CLOSE, SBL_BK_WRITE_CLOSE,
					SBL_BK_ACTIVATING, SBL_BK_WREC_CLOSE:
						bank_bad[gi] = mine;
					SBL_BK_WREC:
						bank_bad[gi] = mine && !bwr;
					SBL_BK_PRECHARGING:
						bank_bad[gi] = mine && !bpre;
					default: bank_bad[gi] = 1'b0;
				endcase
			end

			always_ff @(posedge REF_CLK) begin
				if (RST) begin
					st_reg    <= SBL_BK_IDLE;
					cnt_reg   <= CNT_ZERO;
					burst_reg <= CNT_ZERO;
				end else begin
					if (cnt_reg != CNT_ZERO) begin
						cnt_reg <= cnt_reg - 8'h01;
					end
					if (burst_reg != CNT_ZERO) begin
						burst_reg <= burst_reg - 8'h01;
					end
					case (st_reg)
						SBL_BK_IDLE: begin
							if (cmd == SBL_CMD_ROW_OPEN && hit) begin
								st_reg  <= SBL_BK_ACTIVATING;
								cnt_reg <= ACT_ACCESS_CYC - 8'h01;
							end
						end
						SBL_BK_ACTIVATING: begin
							if (cnt_reg == CNT_ZERO) begin
								st_reg <= SBL_BK_ACTIVE;
							end
						end
						SBL_BK_ACTIVE, SBL_BK_WREC, SBL_BK_READ, SBL_BK_WRITE: begin
							if ((brd || bwr) && !bank_bad[gi]) begin
								burst_reg <= (BURST_LEN8 ? BURST8_CYC : BURST4_CYC) - 8'h01;
								if (brd) begin
									st_reg <= cmd_close ? SBL_BK_READ_CLOSE : SBL_BK_READ;
								end else begin
									st_reg <= cmd_close ? SBL_BK_WRITE_CLOSE : SBL_BK_WRITE;
								end
							end else if (bpre && st_reg == SBL_BK_ACTIVE) begin
								st_reg  <= SBL_BK_PRECHARGING;
								cnt_reg <= PRECHARGE_CYC - 8'h01;
							end else if (st_reg == SBL_BK_READ && burst_reg == CNT_ZERO) begin
								st_reg <= SBL_BK_ACTIVE;
							end else if (st_reg == SBL_BK_WRITE && burst_reg == CNT_ZERO) begin
								st_reg  <= SBL_BK_WREC;
								cnt_reg <= WRITE_RECOVERY_CYC - 8'h01;
							end else if (st_reg == SBL_BK_WREC && cnt_reg == CNT_ZERO) begin
								st_reg <= SBL_BK_ACTIVE;
							end
						end
						SBL_BK_READ_CLOSE: begin
							if (burst_reg == CNT_ZERO) begin
								st_reg  <= SBL_BK_PRECHARGING;
								cnt_reg <= PRECHARGE_CYC - 8'h01;
							end
						end
						SBL_BK_WRITE_CLOSE: begin
							if (burst_reg == CNT_ZERO) begin
								st_reg  <= SBL_BK_WREC_CLOSE;
								cnt_reg <= WRITE_RECOVERY_CYC - 8'h01;
							end
						end
						SBL_BK_WREC_CLOSE: begin
							if (cnt_reg == CNT_ZERO) begin
								st_reg  <= SBL_BK_PRECHARGING;
								cnt_reg <= PRECHARGE_CYC - 8'h01;
							end
						end
						SBL_BK_PRECHARGING: begin
							if (cnt_reg == CNT_ZERO) begin
								st_reg <= SBL_BK_IDLE;
							end
						end
						default: st_reg <= SBL_BK_IDLE;
					endcase
				end
			end

			always_ff @(posedge REF_CLK) begin
				if (RST) begin
					BANK_IDLE[gi]       <= 1'b1;
					BANK_ROW_ACTIVE[gi] <= 1'b0;
				end else begin
					BANK_IDLE[gi]       <= st_reg == SBL_BK_IDLE && glob_reg == SBL_GL_NONE;
					BANK_ROW_ACTIVE[gi] <= st_reg == SBL_BK_ACTIVE;
				end
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// legality flag and command echo
	// ------------------------------------------------------------
	logic glob_bad;
	assign glob_bad = (glob_reg != SBL_GL_NONE && cmd_sel)
		|| ((cmd == SBL_CMD_REFRESH || cmd == SBL_CMD_MODE_LOAD) && !all_idle);

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ALL_IDLE    <= 1'b1;
			CMD_VALID   <= 1'b0;
			CMD_CODE    <= 4'h0;
			CMD_BANK    <= '0;
			ILLEGAL_CMD <= 1'b0;
		end else begin
			ALL_IDLE    <= all_idle && glob_reg == SBL_GL_NONE;
			CMD_VALID   <= cmd_sel;
			CMD_CODE    <= cmd;
			CMD_BANK    <= cmd_ba;
			ILLEGAL_CMD <= glob_bad || (|bank_bad);
		end
	end
endmodule

// ### design/sbl_if.sv
// command link between memory controller and the bank legality logic
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface sbl_if;
	import sbl_pkg::*;
	logic            cs_n;
	logic            ras_n;
	logic            cas_n;
	logic            we_n;
	logic [BA_W-1:0] ba;
	logic            close_flag_bit;
	logic            cke;

	modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, close_flag_bit, cke);
	modport dev  (input  cs_n, ras_n, cas_n, we_n, ba, close_flag_bit, cke);
endinterface

// ### design/sbl_pkg.sv
// constants and types shared by both ends of the bank command link
// assumes one clock (REF_CLK, 200 MHz) and a synchronous active-high reset
package sbl_pkg;
	localparam int NUM_BANKS = 4;
	localparam int BA_W      = 2;
	localparam int CNT_W     = 8;

	localparam int CLK_PERIOD_PS = 5000;
	// times in ps, counts rounded up (least times)
	localparam int PRECHARGE_PERIOD_PS  = 15000;
	localparam int ACT_ACCESS_DELAY_PS  = 15000;
	localparam int WRITE_RECOVERY_PS    = 15000;
	localparam int ROW_CYCLE_TIME_PS    = 60000;
	localparam int MODE_SET_DELAY_CYC   = 2;
	localparam int BURST_LEN_DEF        = 8;
	localparam int BOUNDARY_BEATS       = 4;
	localparam int BEATS_PER_CYC        = 2;

	localparam logic [CNT_W-1:0] PRECHARGE_CYC =
		CNT_W'((PRECHARGE_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] ACT_ACCESS_CYC =
		CNT_W'((ACT_ACCESS_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] WRITE_RECOVERY_CYC =
		CNT_W'((WRITE_RECOVERY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] ROW_CYCLE_CYC =
		CNT_W'((ROW_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [CNT_W-1:0] MODE_SET_CYC = CNT_W'(MODE_SET_DELAY_CYC);
	localparam logic [CNT_W-1:0] BURST8_CYC   = CNT_W'(BURST_LEN_DEF / BEATS_PER_CYC);
	localparam logic [CNT_W-1:0] BURST4_CYC   = CNT_W'(BOUNDARY_BEATS / BEATS_PER_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO     = 8'h00;

	typedef enum logic [3:0] {
		SBL_CMD_DESELECT  = 4'h0,
		SBL_CMD_NO_OP     = 4'h1,
		SBL_CMD_READ      = 4'h2,
		SBL_CMD_WRITE     = 4'h3,
		SBL_CMD_ROW_OPEN  = 4'h4,
		SBL_CMD_PRECHARGE = 4'h5,
		SBL_CMD_REFRESH   = 4'h6,
		SBL_CMD_MODE_LOAD = 4'h7
	} sbl_cmd_e;

	typedef enum logic [10:0] {
		SBL_BK_IDLE       = 11'h001,
		SBL_BK_ACTIVATING = 11'h002,
		SBL_BK_ACTIVE     = 11'h004,
		SBL_BK_READ       = 11'h008,
		SBL_BK_WRITE      = 11'h010,
		SBL_BK_READ_CLOSE = 11'h020,
		SBL_BK_WRITE_CLOSE= 11'h040,
		SBL_BK_WREC       = 11'h080,
		SBL_BK_WREC_CLOSE = 11'h100,
		SBL_BK_PRECHARGING= 11'h200,
		SBL_BK_GLOBAL     = 11'h400
	} sbl_bank_e;

	typedef enum logic [2:0] {
		SBL_GL_NONE    = 3'h1,
		SBL_GL_REFRESH = 3'h2,
		SBL_GL_MODE    = 3'h4
	} sbl_glob_e;

	// strobe levels cs_n,ras_n,cas_n,we_n -> command
	function automatic sbl_cmd_e sbl_decode(input logic [3:0] pins);
		sbl_cmd_e c;
		c = SBL_CMD_DESELECT;
		if (!pins[3]) begin
			case (pins[2:0])
				3'h7:    c = SBL_CMD_NO_OP;
				3'h5:    c = SBL_CMD_READ;
				3'h4:    c = SBL_CMD_WRITE;
				3'h3:    c = SBL_CMD_ROW_OPEN;
				3'h2:    c = SBL_CMD_PRECHARGE;
				3'h1:    c = SBL_CMD_REFRESH;
				3'h0:    c = SBL_CMD_MODE_LOAD;
				default: c = SBL_CMD_DESELECT;
			endcase
		end
		return c;
	endfunction

	function automatic logic [3:0] sbl_encode(input sbl_cmd_e c);
		logic [3:0] p;
		p = 4'h7;
		case (c)
			SBL_CMD_DESELECT:  p = 4'hf;
			SBL_CMD_NO_OP:     p = 4'h7;
			SBL_CMD_READ:      p = 4'h5;
			SBL_CMD_WRITE:     p = 4'h4;
			SBL_CMD_ROW_OPEN:  p = 4'h3;
			SBL_CMD_PRECHARGE: p = 4'h2;
			SBL_CMD_REFRESH:   p = 4'h1;
			SBL_CMD_MODE_LOAD: p = 4'h0;
			default:           p = 4'hf;
		endcase
		return p;
	endfunction
endpackage

// ### tb/sbl_props.sv
// link checker: timing of what the controller end puts on the command pins
// assumes it sits beside the interface that joins both ends, one clock
`timescale 1ns/1ps
module sbl_props
	import sbl_pkg::*;
(
	input wire logic            REF_CLK,
	input wire logic            RST,
	input wire logic            cs_n,
	input wire logic            ras_n,
	input wire logic            cas_n,
	input wire logic            we_n,
	input wire logic [BA_W-1:0] ba,
	input wire logic            close_flag_bit,
	input wire logic            cke
);
	// ------------------------------------------------------------
	// decode and guard counters
	// ------------------------------------------------------------
	logic [3:0]       pins;
	logic             rd, wr, act, pre, rfr, mld, busy, same_bank;
	logic [CNT_W-1:0] quiet_reg;
	logic [2:0]       guard_cnt_reg;
	logic [BA_W-1:0]  guard_bank_reg;
	logic [1:0]       guard_kind_reg;
	assign pins = {cs_n, ras_n, cas_n, we_n};
	assign rd   = pins == 4'h5;
	assign wr   = pins == 4'h4;
	assign act  = pins == 4'h3;
	assign pre  = pins == 4'h2;
	assign rfr  = pins == 4'h1;
	assign mld  = pins == 4'h0;
	assign busy = !cs_n && pins[2:0] != 3'h7;
	assign same_bank = ba == guard_bank_reg || pre && close_flag_bit || rfr || mld;

	// refresh keeps the whole device quiet for the row cycle
	always_ff @(posedge REF_CLK) begin
		if (RST)
			quiet_reg <= CNT_ZERO;
		else if (rfr)
			quiet_reg <= ROW_CYCLE_CYC - 8'h01;
		else if (quiet_reg != CNT_ZERO)
			quiet_reg <= quiet_reg - 8'h01;
	end

	// shortest burst of four beats: counts are lower bounds, so a longer burst never fires
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			guard_cnt_reg <= 3'h0;
		end else if ((rd || wr) && close_flag_bit || wr) begin
			guard_cnt_reg  <= (wr && close_flag_bit) ? 3'h7 : 3'h4;
			guard_bank_reg <= ba;
			guard_kind_reg <= {wr && !close_flag_bit, wr && close_flag_bit};
		end else if (guard_cnt_reg != 3'h0) begin
			guard_cnt_reg <= guard_cnt_reg - 3'h1;
		end
	end

	// banks left open on the link, for the all-idle rule
	logic [NUM_BANKS-1:0] open_reg;
	always_ff @(posedge REF_CLK) begin
		if (RST)
			open_reg <= 4'h0;
		else if (act)
			open_reg[ba] <= 1'b1;
		else if (pre && close_flag_bit)
			open_reg <= 4'h0;
		else if (pre || (rd || wr) && close_flag_bit)
			open_reg[ba] <= 1'b0;
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);

	reset_deselect_a: assert property (disable iff (1'b0) RST |=> cs_n)
		else $error("link not deselected after reset");
	clock_enable_a: assert property (1'b1 |=> cke)
		else $error("clock enable dropped");
	act_wait_a: assert property (act |=>
		!((rd || wr || pre) && ba == $past(ba) || pre && close_flag_bit)
		##1 !((rd || wr || pre) && ba == $past(ba, 2) || pre && close_flag_bit))
		else $error("access too soon after row open");
	pre_wait_a: assert property (pre |=>
		!(act && (ba == $past(ba) || $past(close_flag_bit)))
		##1 !(act && (ba == $past(ba, 2) || $past(close_flag_bit, 2))))
		else $error("row open too soon after precharge");
	burst_gap_a: assert property ((rd || wr) |=>
		!(busy && (ba == $past(ba) || rfr || mld || pre && close_flag_bit)))
		else $error("burst interrupted");
	rd_close_a: assert property (guard_cnt_reg != 3'h0 && guard_kind_reg == 2'h0
		|-> !(busy && same_bank)) else $error("command during read with close");
	wr_close_a: assert property (guard_cnt_reg != 3'h0 && guard_kind_reg == 2'h1
		|-> !(busy && same_bank)) else $error("command during write with close");
	wrec_gap_a: assert property (guard_cnt_reg != 3'h0 && guard_kind_reg == 2'h2
		|-> !((rd || act || pre) && same_bank)) else $error("command in write recovery");
	refresh_quiet_a: assert property (quiet_reg != CNT_ZERO |-> !busy)
		else $error("command during refresh");
	mode_quiet_a: assert property (mld |=> !busy)
		else $error("command during mode load");
	all_closed_a: assert property ((rfr || mld) |-> open_reg == 4'h0)
		else $error("refresh or mode load with a bank open");
endmodule

// ### tb/testbench.sv
// bench: controller and device joined on one link, a second device fed by a rule breaker
// assumes the package timing constants and a 200 MHz clock
`timescale 1ns/1ps
module testbench;
	import sbl_pkg::*;
	logic                 ref_clk, rst, rst2, req_valid, req_close, burst_len8, bl8_b;
	logic                 req_ready, issued, all_idle, cmd_valid, illegal_cmd, ill_b;
	logic [3:0]           req_cmd, cmd_code;
	logic [BA_W-1:0]      req_bank, cmd_bank, b;
	logic [NUM_BANKS-1:0] bank_idle, row_active;
	logic [6:0]           e;
	logic [6:0]           exp_q[$];
	logic [3:0]           enc[8];
	sbl_cmd_e             kind[3];
	int                   n_errors, samples_checked, act_mask;
	sbl_if link_a ();
	sbl_if link_b ();

	sbl_ctrl u_sbl_ctrl (.REF_CLK(ref_clk), .RST(rst), .LINK(link_a.ctrl),
		.REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_BANK(req_bank), .REQ_CLOSE(req_close),
		.BURST_LEN8(burst_len8), .REQ_READY(req_ready), .ISSUED(issued));
	sbl_device u_sbl_device (.REF_CLK(ref_clk), .RST(rst), .LINK(link_a.dev),
		.BURST_LEN8(burst_len8), .BANK_IDLE(bank_idle), .BANK_ROW_ACTIVE(row_active),
		.ALL_IDLE(all_idle), .CMD_VALID(cmd_valid), .CMD_CODE(cmd_code), .CMD_BANK(cmd_bank),
		.ILLEGAL_CMD(illegal_cmd));
	sbl_device u_sbl_device_b (.REF_CLK(ref_clk), .RST(rst2), .LINK(link_b.dev),
		.BURST_LEN8(bl8_b), .BANK_IDLE(), .BANK_ROW_ACTIVE(), .ALL_IDLE(), .CMD_VALID(),
		.CMD_CODE(), .CMD_BANK(), .ILLEGAL_CMD(ill_b));
	sbl_props u_sbl_props (.REF_CLK(ref_clk), .RST(rst), .cs_n(link_a.cs_n),
		.ras_n(link_a.ras_n), .cas_n(link_a.cas_n), .we_n(link_a.we_n), .ba(link_a.ba),
		.close_flag_bit(link_a.close_flag_bit), .cke(link_a.cke));

	// ------------------------------------------------------------
	// compare and report
	// ------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmp_cmd(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp);
	endtask
	task automatic cmp_state(input logic [7:0] got, input logic [7:0] exp);
		check(got, exp);
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// decoded commands leave the device in the order the controller took them
	always @(posedge ref_clk) begin
		if (!rst && cmd_valid === 1'b1) begin
			e = exp_q.size() > 0 ? exp_q.pop_front() : 7'h7f;
			cmp_cmd({2'h0, e[6] ? cmd_bank : 2'h0, cmd_code}, {2'h0, e[6] ? e[5:4] : 2'h0, e[3:0]});
		end
		if (!rst && illegal_cmd !== 1'b0)
			cmp_state({7'h0, illegal_cmd}, 8'h00);
	end

	// ------------------------------------------------------------
	// drivers
	// ------------------------------------------------------------
	task automatic req(input sbl_cmd_e c, input logic [BA_W-1:0] bk, input logic cl);
		int n;
		req_cmd = c;
		req_bank = bk;
		req_close = cl;
		req_valid = 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (req_ready !== 1'b1 && n < 400);
		if (n >= 400) begin
			n_errors++;
			complete_run();
		end
		cmp_state({7'h0, issued}, 8'h01);
		exp_q.push_back({!(c inside {SBL_CMD_REFRESH, SBL_CMD_MODE_LOAD}) && !(c == SBL_CMD_PRECHARGE && cl), bk, c});
		if (c == SBL_CMD_ROW_OPEN)
			act_mask[bk] = 1;
		else if (c == SBL_CMD_PRECHARGE)
			act_mask = cl ? 0 : act_mask & ~(1 << bk);
		else if (cl && c != SBL_CMD_REFRESH && c != SBL_CMD_MODE_LOAD)
			act_mask = act_mask & ~(1 << bk);
	endtask

	// one command on the second link, then back to no-op
	task automatic drv(input sbl_cmd_e c, input logic [BA_W-1:0] bk, input logic cl);
		{link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = enc[c];
		link_b.ba = bk;
		link_b.close_flag_bit = cl;
		@(posedge ref_clk);
		#1;
		{link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 4'h7;
	endtask

	// fresh device, set up bank 0, then a third command g cycles after the second
	task automatic run_case(input sbl_cmd_e c1, c2, input logic cl, input int g,
		input sbl_cmd_e c3, input logic [BA_W-1:0] b3, input logic bl8, input logic exp);
		logic seen;
		rst2 = 1'b1;
		bl8_b = bl8;
		repeat (3) @(posedge ref_clk);
		#1;
		rst2 = 1'b0;
		drv(c1, 2'h0, 1'b0);
		repeat (8) @(posedge ref_clk);
		#1;
		drv(c2, 2'h0, cl);
		if (g > 1) begin
			repeat (g - 1) @(posedge ref_clk);
			#1;
		end
		drv(c3, b3, 1'b0);
		seen = 1'b0;
		for (int n = 0; n < 8; n++) begin
			@(posedge ref_clk);
			#1;
			if (ill_b === 1'b1)
				seen = 1'b1;
		end
		cmp_state({7'h0, seen}, {7'h0, exp});
	endtask

	// ------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	initial begin
		enc = '{4'hf, 4'h7, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
		kind = '{SBL_CMD_READ, SBL_CMD_WRITE, SBL_CMD_PRECHARGE};
		n_errors = 0;
		samples_checked = 0;
		act_mask = 0;
		{rst, rst2, req_valid, req_close, burst_len8, bl8_b} = 6'h30;
		req_cmd = 4'h0;
		req_bank = 2'h0;
		{link_b.cs_n, link_b.ras_n, link_b.cas_n, link_b.we_n} = 4'hf;
		link_b.ba = 2'h0;
		link_b.close_flag_bit = 1'b0;
		link_b.cke = 1'b1;
		void'($urandom(32'h88e5));
		repeat (12) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		cmp_state({3'h0, all_idle, bank_idle}, 8'h1f);
		for (int ph = 0; ph < 2; ph++) begin
			burst_len8 = ph[0];
			for (int i = 0; i < 30; i++) begin
				b = 2'($urandom % 4);
				if (act_mask[b])
					req(kind[$urandom % 3], b, 1'($urandom % 2));
				else
					req(SBL_CMD_ROW_OPEN, b, 1'b0);
			end
			req_valid = 1'b0;
			repeat (20) @(posedge ref_clk);
			#1;
			cmp_state(8'(row_active), 8'(act_mask));
			req(SBL_CMD_PRECHARGE, 2'h0, 1'b1);
			req(SBL_CMD_REFRESH, 2'h0, 1'b0);
			req(SBL_CMD_MODE_LOAD, 2'h0, 1'b0);
			req_valid = 1'b0;
			repeat (30) @(posedge ref_clk);
			#1;
			cmp_state({3'h0, all_idle, bank_idle}, 8'h1f);
			cmp_cmd(8'(exp_q.size()), 8'h00);
		end
		run_case(SBL_CMD_DESELECT, SBL_CMD_ROW_OPEN, 1'b0, 1, SBL_CMD_READ, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_DESELECT, SBL_CMD_ROW_OPEN, 1'b0, 1, SBL_CMD_ROW_OPEN, 2'h1, 1'b0, 1'b0);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_PRECHARGE, 1'b0, 1, SBL_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_PRECHARGE, 1'b0, 1, SBL_CMD_PRECHARGE, 2'h0, 1'b0, 1'b0);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_READ, 1'b1, 1, SBL_CMD_PRECHARGE, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_WRITE, 1'b0, 3, SBL_CMD_READ, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_WRITE, 1'b0, 3, SBL_CMD_WRITE, 2'h0, 1'b0, 1'b0);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_WRITE, 1'b1, 3, SBL_CMD_ROW_OPEN, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_DESELECT, SBL_CMD_REFRESH, 1'b0, 2, SBL_CMD_ROW_OPEN, 2'h1, 1'b0, 1'b1);
		run_case(SBL_CMD_DESELECT, SBL_CMD_MODE_LOAD, 1'b0, 1, SBL_CMD_ROW_OPEN, 2'h2, 1'b0, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_READ, 1'b0, 1, SBL_CMD_READ, 2'h0, 1'b0, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_READ, 1'b0, 2, SBL_CMD_WRITE, 2'h0, 1'b1, 1'b1);
		run_case(SBL_CMD_ROW_OPEN, SBL_CMD_READ, 1'b0, 2, SBL_CMD_READ, 2'h0, 1'b1, 1'b0);
		complete_run();
	end
endmodule
